// *** apb_word_decode.sv ***
// word address decoder for the register bank
// assumes byte addresses; only aligned words hit
module apb_word_decode (
   // bus address
   input wire logic [dyn_pull_pkg::ADDR_W-1:0] paddr,
   // one-hot select and hit
   output logic [dyn_pull_pkg::SEL_W-1:0] sel,
   output logic hit
);

   always_comb begin
      sel = '0;
      for (int i = 0; i < dyn_pull_pkg::NUM_REGS; i++) begin
         if (paddr == {2'h0, dyn_pull_pkg::REG_IDX[i], 2'h0}) begin
            sel[i] = 1'h1;
         end
      end
      sel[dyn_pull_pkg::R_STAT] = (paddr == dyn_pull_pkg::STATUS_ADDR);
      hit = |sel;
   end

endmodule

// *** dyn_pull_pkg.sv ***
// constants for the dynamics and pin-pull register bank
// assumes a 32-bit APB slave with 12-bit byte addresses
package dyn_pull_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // address map: index is the word number, byte address is four times it
   localparam int ADDR_W = 12;
   localparam int NUM_REGS = 4;
   localparam int SEL_W = 5;
   localparam logic [7:0] IDX_EQ = 8'h79;
   localparam logic [7:0] IDX_PULL = 8'h7A;
   localparam logic [7:0] IDX_C1 = 8'h7B;
   localparam logic [7:0] IDX_C2 = 8'h7C;
   localparam logic [3:0][7:0] REG_IDX = {IDX_C2, IDX_C1, IDX_PULL, IDX_EQ};
   localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h200;

   // slot numbers in the register array and select vector
   localparam int R_EQ = 0;
   localparam int R_PULL = 1;
   localparam int R_C1 = 2;
   localparam int R_C2 = 3;
   localparam int R_STAT = 4;

   ////////////////////////////////////////////////////////////////////////////
   // reset values and writable-bit masks
   localparam logic [3:0][15:0] REG_RESET = {16'h0000, 16'h0F08, 16'h0000, 16'h4000};
   localparam logic [3:0][15:0] REG_MASK = {16'hFFFC, 16'hCF3F, 16'h00FF, 16'hFFFF};

   ////////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int PULL_MASTER_PU = 7;
   localparam int PULL_MASTER_PD = 6;
   localparam int PULL_DATA_PU = 5;
   localparam int PULL_DATA_PD = 4;
   localparam int PULL_FRAME_PU = 3;
   localparam int PULL_FRAME_PD = 2;
   localparam int PULL_BIT_PU = 1;
   localparam int PULL_BIT_PD = 0;
   localparam int C1_ENA = 15;
   localparam int C1_PATH = 14;
   localparam int C1_SMOOTH = 11;
   localparam int C1_QR = 10;
   localparam int C1_CLIP = 9;
   localparam int C1_HYST = 8;
   localparam int C1_HLVL_LSB = 4;
   localparam int C1_MING_LSB = 2;
   localparam int C1_MAXG_LSB = 0;
   localparam int C2_ATT_LSB = 12;
   localparam int C2_DEC_LSB = 8;
   localparam int C2_THR_LSB = 2;

   ////////////////////////////////////////////////////////////////////////////
   // legal code limits
   localparam logic [1:0] HYST_RSV = 2'h3;
   localparam logic [3:0] ATT_MIN_OK = 4'h1;
   localparam logic [3:0] ATT_MAX_OK = 4'hB;
   localparam logic [3:0] DEC_MAX_OK = 4'h8;
   localparam logic [5:0] THR_MAX_OK = 6'h3C;

   // status register bits
   localparam int ST_W = 4;
   localparam int ST_HYST_RSV = 0;
   localparam int ST_ATT_RSV = 1;
   localparam int ST_DEC_RSV = 2;
   localparam int ST_THR_RSV = 3;

endpackage

// *** dynamics_and_pull_config.sv ***
// APB register bank for the dynamics controller, band-five gain and pin pulls
// assumes an APB master with zero or more idle cycles between transfers
//
// How it works
// - full 16-bit band-five peak-gain coefficient register
// - bits 7/6: master clock pull-up/pull-down
// - bits 5/4: playback data pull-up/pull-down
// - bits 3/2: frame clock pull-up/pull-down
// - bits 1/0: bit clock pull-up/pull-down
// - bit 8 hysteresis enable, resets to one
// - bits 5:4 hysteresis level, 11 reserved
// - bits 3:2 maximum attenuation, resets to 10
// - bits 1:0 maximum boost, resets to 00
// - bits 15:12 attack time, 0000/11xx reserved
// - bits 11:8 decay time, 1001+ reserved
// - bits 7:2 threshold, above 111100 reserved
module dynamics_and_pull_config (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [dyn_pull_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // equaliser coefficient
   output logic [15:0] band5_peak_gain_coeff,
   // pin pull enables
   output logic master_clock_pullup_en,
   output logic master_clock_pulldown_en,
   output logic playback_data_pullup_en,
   output logic playback_data_pulldown_en,
   output logic frame_clock_pullup_en,
   output logic frame_clock_pulldown_en,
   output logic bit_clock_pullup_en,
   output logic bit_clock_pulldown_en,
   // dynamics controller settings
   output logic dynamics_enable,
   output logic dynamics_playback_select,
   output logic gain_smoothing_enable,
   output logic quick_release_enable,
   output logic anti_clip_enable,
   output logic smoothing_hysteresis_enable,
   output logic [1:0] smoothing_hysteresis_level,
   output logic [1:0] max_attenuation_select,
   output logic [1:0] max_boost_select,
   output logic [3:0] gain_attack_time,
   output logic [3:0] gain_decay_time,
   output logic [5:0] compressor_threshold
);

   ////////////////////////////////////////////////////////////////////////////
   // state

   typedef struct packed {
      logic [3:0][15:0] regs;
      logic [31:0] rdata;
      logic ready;
      logic err;
   } state_t;

   state_t state_q;
   state_t state_d;

   logic [dyn_pull_pkg::SEL_W-1:0] sel;
   logic hit;
   logic [dyn_pull_pkg::ST_W-1:0] rsv;
   logic setup;
   logic wr_commit;
   logic [3:0] wr_lo;
   logic [3:0] wr_hi;
   logic [3:0][15:0] reg_nxt;
   logic [15:0] rd_word;

   ////////////////////////////////////////////////////////////////////////////
   // decode and reserved-code flags

   apb_word_decode apb_word_decode_inst (
      .paddr(paddr),
      .sel(sel),
      .hit(hit)
   );

   dynamics_code_check dynamics_code_check_inst (
      .ctrl_one(state_q.regs[dyn_pull_pkg::R_C1]),
      .ctrl_two(state_q.regs[dyn_pull_pkg::R_C2]),
      .rsv(rsv)
   );

   ////////////////////////////////////////////////////////////////////////////
   // write path

   assign setup = psel & ~penable;
   // writes land on the access edge where pready is seen high
   assign wr_commit = psel & penable & state_q.ready & pwrite & ~state_q.err;

   // per-register byte-lane merge, unwritable bits forced to zero
   for (genvar i = 0; i < dyn_pull_pkg::NUM_REGS; i++) begin : g_reg
      assign wr_lo[i] = wr_commit & sel[i] & pstrb[0];
      assign wr_hi[i] = wr_commit & sel[i] & pstrb[1];
      assign reg_nxt[i] = {wr_hi[i] ? pwdata[15:8] : state_q.regs[i][15:8],
                           wr_lo[i] ? pwdata[7:0] : state_q.regs[i][7:0]} & dyn_pull_pkg::REG_MASK[i];
   end

   ////////////////////////////////////////////////////////////////////////////
   // read mux

   always_comb begin
      rd_word = 16'h0000;
      for (int i = 0; i < dyn_pull_pkg::NUM_REGS; i++) begin
         if (sel[i]) begin
            rd_word = state_q.regs[i];
         end
      end
      if (sel[dyn_pull_pkg::R_STAT]) begin
         rd_word = {12'h000, rsv};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      state_d = state_q;
      state_d.regs = reg_nxt;
      // answer one cycle after setup: one access cycle, no wait
      state_d.ready = setup;
      state_d.err = 1'h0;
      if (setup) begin
         state_d.rdata = {16'h0000, rd_word};
         state_d.err = ~hit;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q.regs <= dyn_pull_pkg::REG_RESET;
         state_q.rdata <= 32'h0000_0000;
         state_q.ready <= 1'h0;
         state_q.err <= 1'h0;
      end else begin
         state_q <= state_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign prdata = state_q.rdata;
   assign pready = state_q.ready;
   assign pslverr = state_q.err;

   assign band5_peak_gain_coeff = state_q.regs[dyn_pull_pkg::R_EQ];

   assign master_clock_pullup_en = state_q.regs[dyn_pull_pkg::R_PULL][dyn_pull_pkg::PULL_MASTER_PU];
   assign master_clock_pulldown_en = state_q.regs[dyn_pull_pkg::R_PULL][dyn_pull_pkg::PULL_MASTER_PD];
   assign playback_data_pullup_en = state_q.regs[dyn_pull_pkg::R_PULL][dyn_pull_pkg::PULL_DATA_PU];
   assign playback_data_pulldown_en = state_q.regs[dyn_pull_pkg::R_PULL][dyn_pull_pkg::PULL_DATA_PD];
   assign frame_clock_pullup_en = state_q.regs[dyn_pull_pkg::R_PULL][dyn_pull_pkg::PULL_FRAME_PU];
   assign frame_clock_pulldown_en = state_q.regs[dyn_pull_pkg::R_PULL][dyn_pull_pkg::PULL_FRAME_PD];
   assign bit_clock_pullup_en = state_q.regs[dyn_pull_pkg::R_PULL][dyn_pull_pkg::PULL_BIT_PU];
   assign bit_clock_pulldown_en = state_q.regs[dyn_pull_pkg::R_PULL][dyn_pull_pkg::PULL_BIT_PD];

   assign dynamics_enable = state_q.regs[dyn_pull_pkg::R_C1][dyn_pull_pkg::C1_ENA];
   assign dynamics_playback_select = state_q.regs[dyn_pull_pkg::R_C1][dyn_pull_pkg::C1_PATH];
   assign gain_smoothing_enable = state_q.regs[dyn_pull_pkg::R_C1][dyn_pull_pkg::C1_SMOOTH];
   assign quick_release_enable = state_q.regs[dyn_pull_pkg::R_C1][dyn_pull_pkg::C1_QR];
   assign anti_clip_enable = state_q.regs[dyn_pull_pkg::R_C1][dyn_pull_pkg::C1_CLIP];
   assign smoothing_hysteresis_enable = state_q.regs[dyn_pull_pkg::R_C1][dyn_pull_pkg::C1_HYST];
   assign smoothing_hysteresis_level = state_q.regs[dyn_pull_pkg::R_C1][dyn_pull_pkg::C1_HLVL_LSB +: 2];
   assign max_attenuation_select = state_q.regs[dyn_pull_pkg::R_C1][dyn_pull_pkg::C1_MING_LSB +: 2];
   assign max_boost_select = state_q.regs[dyn_pull_pkg::R_C1][dyn_pull_pkg::C1_MAXG_LSB +: 2];

   assign gain_attack_time = state_q.regs[dyn_pull_pkg::R_C2][dyn_pull_pkg::C2_ATT_LSB +: 4];
   assign gain_decay_time = state_q.regs[dyn_pull_pkg::R_C2][dyn_pull_pkg::C2_DEC_LSB +: 4];
   assign compressor_threshold = state_q.regs[dyn_pull_pkg::R_C2][dyn_pull_pkg::C2_THR_LSB +: 6];

   ////////////////////////////////////////////////////////////////////////////
   // checks

   property p_eq_write;
      @(posedge pclk) disable iff (!presetn)
      (wr_lo[dyn_pull_pkg::R_EQ] && wr_hi[dyn_pull_pkg::R_EQ]) |=> band5_peak_gain_coeff == $past(pwdata[15:0]);
   endproperty
   a_eq_write: assert property (p_eq_write)
      else $error("band five coefficient not taken");

   property p_mclk_pull;
      @(posedge pclk) disable iff (!presetn)
      wr_lo[dyn_pull_pkg::R_PULL] |=> {master_clock_pullup_en, master_clock_pulldown_en} == $past(pwdata[7:6]);
   endproperty
   a_mclk_pull: assert property (p_mclk_pull)
      else $error("master clock pull bits wrong");

   property p_data_pull;
      @(posedge pclk) disable iff (!presetn)
      wr_lo[dyn_pull_pkg::R_PULL] |=> {playback_data_pullup_en, playback_data_pulldown_en} == $past(pwdata[5:4]);
   endproperty
   a_data_pull: assert property (p_data_pull)
      else $error("playback data pull bits wrong");

   property p_frame_pull;
      @(posedge pclk) disable iff (!presetn)
      wr_lo[dyn_pull_pkg::R_PULL] |=> {frame_clock_pullup_en, frame_clock_pulldown_en} == $past(pwdata[3:2]);
   endproperty
   a_frame_pull: assert property (p_frame_pull)
      else $error("frame clock pull bits wrong");

   property p_bit_pull;
      @(posedge pclk) disable iff (!presetn)
      !wr_lo[dyn_pull_pkg::R_PULL] |=> $stable({bit_clock_pullup_en, bit_clock_pulldown_en});
   endproperty
   a_bit_pull: assert property (p_bit_pull)
      else $error("bit clock pull changed without a write");

   property p_hyst_hold;
      @(posedge pclk) disable iff (!presetn)
      !wr_hi[dyn_pull_pkg::R_C1] |=> $stable(smoothing_hysteresis_enable);
   endproperty
   a_hyst_hold: assert property (p_hyst_hold)
      else $error("hysteresis enable changed without a write");

   property p_hyst_rsv;
      @(posedge pclk) disable iff (!presetn)
      (wr_lo[dyn_pull_pkg::R_C1] && pwdata[5:4] == 2'h3) |=> rsv[dyn_pull_pkg::ST_HYST_RSV];
   endproperty
   a_hyst_rsv: assert property (p_hyst_rsv)
      else $error("reserved hysteresis level not flagged");

   property p_min_gain;
      @(posedge pclk) disable iff (!presetn)
      wr_lo[dyn_pull_pkg::R_C1] |=> max_attenuation_select == $past(pwdata[3:2]);
   endproperty
   a_min_gain: assert property (p_min_gain)
      else $error("attenuation limit not taken");

   property p_boost_read;
      @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && sel[dyn_pull_pkg::R_C1]) |=> pready && prdata[1:0] == max_boost_select;
   endproperty
   a_boost_read: assert property (p_boost_read)
      else $error("boost limit read back wrong");

   property p_att_rsv;
      @(posedge pclk) disable iff (!presetn)
      (wr_hi[dyn_pull_pkg::R_C2] && pwdata[15:12] == 4'h0) |=> rsv[dyn_pull_pkg::ST_ATT_RSV] && gain_attack_time == 4'h0;
   endproperty
   a_att_rsv: assert property (p_att_rsv)
      else $error("reserved attack code not flagged");

   property p_decay;
      @(posedge pclk) disable iff (!presetn)
      wr_hi[dyn_pull_pkg::R_C2] |=> gain_decay_time == $past(pwdata[11:8]) && rsv[dyn_pull_pkg::ST_DEC_RSV] == (gain_decay_time > 4'h8);
   endproperty
   a_decay: assert property (p_decay)
      else $error("decay time not taken");

   property p_thresh;
      @(posedge pclk) disable iff (!presetn)
      wr_lo[dyn_pull_pkg::R_C2] |=> compressor_threshold == $past(pwdata[7:2]) && rsv[dyn_pull_pkg::ST_THR_RSV] == (compressor_threshold > 6'h3C);
   endproperty
   a_thresh: assert property (p_thresh)
      else $error("threshold not taken");

   property p_enable_path;
      @(posedge pclk) disable iff (!presetn)
      wr_hi[dyn_pull_pkg::R_C1] |=> {dynamics_enable, dynamics_playback_select} == $past(pwdata[15:14]);
   endproperty
   a_enable_path: assert property (p_enable_path)
      else $error("enable or path select not taken");

   property p_features;
      @(posedge pclk) disable iff (!presetn)
      wr_hi[dyn_pull_pkg::R_C1] |=> {gain_smoothing_enable, quick_release_enable, anti_clip_enable} == $past(pwdata[11:9]);
   endproperty
   a_features: assert property (p_features)
      else $error("feature enables not taken");

   property p_unmapped;
      @(posedge pclk) disable iff (!presetn)
      (setup && !hit) |=> pready && pslverr ##1 !pready;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped access not refused");

   property p_one_cycle;
      @(posedge pclk) disable iff (!presetn)
      setup |=> pready ##1 !pready;
   endproperty
   a_one_cycle: assert property (p_one_cycle)
      else $error("ready not a single access cycle");

   property p_bit_pull_write;
      @(posedge pclk) disable iff (!presetn)
      wr_lo[dyn_pull_pkg::R_PULL] |=> {bit_clock_pullup_en, bit_clock_pulldown_en} == $past(pwdata[1:0]);
   endproperty
   a_bit_pull_write: assert property (p_bit_pull_write)
      else $error("bit clock pull bits wrong");

   property p_hyst_write;
      @(posedge pclk) disable iff (!presetn)
      wr_hi[dyn_pull_pkg::R_C1] |=> smoothing_hysteresis_enable == $past(pwdata[8]);
   endproperty
   a_hyst_write: assert property (p_hyst_write)
      else $error("hysteresis enable not taken");

   property p_level_boost;
      @(posedge pclk) disable iff (!presetn)
      wr_lo[dyn_pull_pkg::R_C1] |=> smoothing_hysteresis_level == $past(pwdata[5:4])
         && max_boost_select == $past(pwdata[1:0]);
   endproperty
   a_level_boost: assert property (p_level_boost)
      else $error("hysteresis level or boost limit not taken");

   property p_attack_take;
      @(posedge pclk) disable iff (!presetn)
      wr_hi[dyn_pull_pkg::R_C2] |=> gain_attack_time == $past(pwdata[15:12]);
   endproperty
   a_attack_take: assert property (p_attack_take)
      else $error("attack time not taken");

   property p_status_read;
      @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && sel[dyn_pull_pkg::R_STAT]) |=> pready && !pslverr && prdata[31:4] == 28'h0000000;
   endproperty
   a_status_read: assert property (p_status_read)
      else $error("status read malformed");

   property p_status_ro;
      @(posedge pclk) disable iff (!presetn)
      (psel && penable && pready && pwrite && sel[dyn_pull_pkg::R_STAT])
         |=> $stable({gain_attack_time, gain_decay_time, compressor_threshold, band5_peak_gain_coeff});
   endproperty
   a_status_ro: assert property (p_status_ro)
      else $error("status write changed settings");

   property p_pull_upper;
      @(posedge pclk) disable iff (!presetn)
      (setup && sel[dyn_pull_pkg::R_PULL]) |=> prdata[31:8] == 24'h000000;
   endproperty
   a_pull_upper: assert property (p_pull_upper)
      else $error("undefined pull bits read nonzero");

   property p_unmapped_data;
      @(posedge pclk) disable iff (!presetn)
      (setup && !hit) |=> prdata == 32'h0000_0000;
   endproperty
   a_unmapped_data: assert property (p_unmapped_data)
      else $error("unmapped read data not zero");

endmodule

// *** dynamics_code_check.sv ***
// flags reserved codes held in the dynamics control words
// assumes the words are stored as written
module dynamics_code_check (
   // stored control words
   input wire logic [15:0] ctrl_one,
   input wire logic [15:0] ctrl_two,
   // reserved-code flags
   output logic [dyn_pull_pkg::ST_W-1:0] rsv
);

   logic [1:0] hlvl;
   logic [3:0] att;
   logic [3:0] dec;
   logic [5:0] thr;

   always_comb begin
      hlvl = ctrl_one[dyn_pull_pkg::C1_HLVL_LSB +: 2];
      att = ctrl_two[dyn_pull_pkg::C2_ATT_LSB +: 4];
      dec = ctrl_two[dyn_pull_pkg::C2_DEC_LSB +: 4];
      thr = ctrl_two[dyn_pull_pkg::C2_THR_LSB +: 6];
      rsv = '0;
      rsv[dyn_pull_pkg::ST_HYST_RSV] = (hlvl == dyn_pull_pkg::HYST_RSV);
      rsv[dyn_pull_pkg::ST_ATT_RSV] = (att < dyn_pull_pkg::ATT_MIN_OK) || (att > dyn_pull_pkg::ATT_MAX_OK);
      rsv[dyn_pull_pkg::ST_DEC_RSV] = (dec > dyn_pull_pkg::DEC_MAX_OK);
      rsv[dyn_pull_pkg::ST_THR_RSV] = (thr > dyn_pull_pkg::THR_MAX_OK);
   end

endmodule

// *** tb_top.sv ***
// self-checking bench for the dynamics and pin-pull register bank
// assumes a zero-wait APB slave with a live reserved-code status word
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   // traffic is about 450 cycles; ample margin
   localparam int TIMEOUT_CYCLES = 2000;
   localparam logic [3:0][15:0] MASK = {16'hFFFC, 16'hCF3F, 16'h00FF, 16'hFFFF};
   localparam logic [3:0][15:0] RST = {16'h0000, 16'h0F08, 16'h0000, 16'h4000};

   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [dyn_pull_pkg::ADDR_W-1:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [3:0] pstrb = 4'h0;
   logic [31:0] prdata;
   logic pready, pslverr;
   logic [15:0] band5_peak_gain_coeff;
   logic mc_pu, mc_pd, pd_pu, pd_pd, fc_pu, fc_pd, bc_pu, bc_pd;
   logic ena, path, smooth, qr, clip, hyst;
   logic [1:0] hlvl, ming, maxg;
   logic [3:0] att, dec;
   logic [5:0] thr;
   logic [3:0][15:0] model_q;
   logic [31:0] rd_data;
   logic rd_err;
   int bad_count = 0;
   int checked = 0;
   int cycles = 0;

   dynamics_and_pull_config dynamics_and_pull_config_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .band5_peak_gain_coeff(band5_peak_gain_coeff),
      .master_clock_pullup_en(mc_pu), .master_clock_pulldown_en(mc_pd),
      .playback_data_pullup_en(pd_pu), .playback_data_pulldown_en(pd_pd),
      .frame_clock_pullup_en(fc_pu), .frame_clock_pulldown_en(fc_pd),
      .bit_clock_pullup_en(bc_pu), .bit_clock_pulldown_en(bc_pd),
      .dynamics_enable(ena), .dynamics_playback_select(path), .gain_smoothing_enable(smooth),
      .quick_release_enable(qr), .anti_clip_enable(clip), .smoothing_hysteresis_enable(hyst),
      .smoothing_hysteresis_level(hlvl), .max_attenuation_select(ming), .max_boost_select(maxg),
      .gain_attack_time(att), .gain_decay_time(dec), .compressor_threshold(thr)
   );

   initial begin
      forever #2 pclk = ~pclk;
   end

   ////////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic [11:0] addr_of(input int s);
      return {2'b00, dyn_pull_pkg::REG_IDX[s], 2'b00};
   endfunction

   function automatic logic [31:0] status_exp();
      logic [3:0] a;
      a = model_q[3][15:12];
      return {28'h0, model_q[3][7:2] > 6'h3C, model_q[3][11:8] > 4'h8, a == 4'h0 || a > 4'hB,
              model_q[2][5:4] == 2'h3};
   endfunction

   task automatic tally_and_finish();
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == TIMEOUT_CYCLES) begin
         bad_count++;
         $display("unexpected at %0t: run did not finish in time", $time);
         tally_and_finish();
      end
   end

   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: read %h, wanted %h", $time, got, exp);
      end
   endtask

   task automatic cmp_err(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: error flag %b, wanted %b", $time, got, exp);
      end
   endtask

   task automatic cmp_cfg();
      logic [49:0] got;
      logic [49:0] exp;
      got = {band5_peak_gain_coeff, mc_pu, mc_pd, pd_pu, pd_pd, fc_pu, fc_pd, bc_pu, bc_pd,
             ena, path, smooth, qr, clip, hyst, hlvl, ming, maxg, att, dec, thr};
      exp = {model_q[0], model_q[1][7:0], model_q[2][15:14], model_q[2][11:8], model_q[2][5:0],
             model_q[3][15:2]};
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: outputs %h, wanted %h", $time, got, exp);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // apb master: called just after an edge, leaves the request up for back to back use
   task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] data,
                       input logic [3:0] strb);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= data;
      pstrb <= strb;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // only the bench timeout ends this wait
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd_data = prdata;
      rd_err = pslverr;
   endtask

   task automatic bus_idle();
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic write_reg(input logic [11:0] addr, input logic [15:0] data, input logic [3:0] strb);
      logic [15:0] lane;
      logic hit;
      lane = {{8{strb[1]}}, {8{strb[0]}}};
      hit = (addr === dyn_pull_pkg::STATUS_ADDR);
      xfer(1'b1, addr, {16'h0000, data}, strb);
      for (int s = 0; s < 4; s++) begin
         if (addr === addr_of(s)) begin
            hit = 1'b1;
            model_q[s] = (model_q[s] & ~(lane & MASK[s])) | (data & lane & MASK[s]);
         end
      end
      cmp_err(rd_err, !hit);
   endtask

   task automatic read_check(input logic [11:0] addr, input logic [31:0] exp, input logic exp_err);
      xfer(1'b0, addr, 32'h00000000, 4'h0);
      cmp_word(rd_data, exp);
      cmp_err(rd_err, exp_err);
   endtask

   task automatic read_all();
      for (int s = 0; s < 4; s++) begin
         read_check(addr_of(s), {16'h0000, model_q[s]}, 1'b0);
      end
      read_check(dyn_pull_pkg::STATUS_ADDR, status_exp(), 1'b0);
      bus_idle();
      cmp_cfg();
   endtask

   task automatic reset_dut();
      presetn <= 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      model_q = RST;
      @(posedge pclk);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // test sequence
   initial begin
      model_q = RST;
      reset_dut();
      read_all();
      for (int b = 0; b < 16; b++) begin
         write_reg(addr_of(1), 16'h0001 << b, 4'h3);
         read_check(addr_of(1), {16'h0000, model_q[1]}, 1'b0);
         bus_idle();
         cmp_cfg();
      end
      for (int s = 0; s < 4; s++) begin
         write_reg(addr_of(s), 16'hFFFF, 4'h3);
      end
      read_all();
      write_reg(addr_of(0), 16'h1234, 4'h2);
      write_reg(addr_of(0), 16'h5678, 4'h1);
      read_check(addr_of(0), {16'h0000, model_q[0]}, 1'b0);
      for (int i = 0; i < 4; i++) begin
         write_reg(addr_of(2), 16'(i * 16'h0015) | (i[0] ? 16'h0100 : 16'h0000) | 16'h4400, 4'h3);
         read_all();
      end
      for (int i = 0; i < 16; i++) begin
         write_reg(addr_of(3), {4'(i), 4'(15 - i), 6'(6'h38 + 3'(i)), 2'b11}, 4'h3);
         read_all();
      end
      write_reg(12'h1F4, 16'hFFFF, 4'h3);
      write_reg(12'h1E5, 16'hFFFF, 4'h3);
      write_reg(dyn_pull_pkg::STATUS_ADDR, 16'hFFFF, 4'h3);
      read_check(12'h1F4, 32'h00000000, 1'b1);
      read_check(12'h1E9, 32'h00000000, 1'b1);
      read_check(12'h000, 32'h00000000, 1'b1);
      read_all();
      reset_dut();
      read_all();
      tally_and_finish();
   end

endmodule
